//--- logic/ddpm_defs.vh
`ifndef DDPM_DEFS_VH
`define DDPM_DEFS_VH

// register indices; byte address on the bus is four times the index
`define DDPM_IDX_PINS_A 6'h0C
`define DDPM_IDX_PINS_B 6'h0D
`define DDPM_IDX_AUDIO 6'h0E
`define DDPM_IDX_SUBBANK 6'h0F
`define DDPM_IDX_STATUS 6'h10
`define DDPM_IDX_LAST_MAIN 6'h0B

// bus geometry
`define DDPM_ADDR_W 8
`define DDPM_IDX_MSB 7
`define DDPM_IDX_LSB 2
`define DDPM_RESP_OKAY 2'h0
`define DDPM_RESP_SLVERR 2'h2

// power-on defaults
`define DDPM_RST_PINS_A 4'h2
`define DDPM_RST_PINS_B 4'hF
`define DDPM_RST_AUDIO 4'h4
`define DDPM_RST_SUBBANK 4'h0

// versatile_pin_control_a fields
`define DDPM_A_EXT_OFFTRACK 0
`define DDPM_A_SINGLE_KILL 1
`define DDPM_A_PIN3_LEVEL 2

// versatile_pin_control_b fields and codes
`define DDPM_B_PIN4_LSB 0
`define DDPM_B_PIN4_MSB 1
`define DDPM_B_PIN5_LSB 2
`define DDPM_B_PIN5_MSB 3
`define DDPM_B_FOUR_LINE 4'h0
`define DDPM_PIN_LOW 2'h2
`define DDPM_PIN_HIGH 2'h3
`define DDPM_PIN_SIGNAL 2'h1

// audio_lock_brake_control fields
`define DDPM_E_BRAKE_SIX 0
`define DDPM_E_LOCK_DISC 1
`define DDPM_E_AUDIO_LSB 2
`define DDPM_E_AUDIO_MSB 3
`define DDPM_E_AUDIO_ON 2'h1

// subcode_and_bank_select fields
`define DDPM_F_ALT_BANK 0
`define DDPM_F_SUB_ON 2
`define DDPM_F_THREE_WIRE 3

// status register fields
`define DDPM_S_PIN_ONE 0
`define DDPM_S_OFFTRACK 1
`define DDPM_S_ALT_BANK 2
`define DDPM_S_FOUR_LINE 3

`endif

//--- logic/ddpm_regs.v
// The AXI4-Lite register port was decided locally.

`include "ddpm_defs.vh"

`default_nettype none

module ddpm_regs (
  input wire I_CLK,
  input wire I_NRST,
  // axi4-lite slave
  input wire [`DDPM_ADDR_W-1:0] I_AWADDR,
  input wire [2:0] I_AWPROT,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  input wire [`DDPM_ADDR_W-1:0] I_ARADDR,
  input wire [2:0] I_ARPROT,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  // pass-through write ports for main and shadow registers
  output reg O_MAIN_WE,
  output reg [3:0] O_MAIN_ADDR,
  output reg [3:0] O_MAIN_DATA,
  output reg O_SHADOW_WE,
  output reg [3:0] O_SHADOW_ADDR,
  output reg [3:0] O_SHADOW_DATA,
  // decoder-side sources
  input wire I_PIN_ONE,
  input wire I_OFFTRACK_INT,
  input wire I_KILL_L,
  input wire I_KILL_R,
  input wire I_SUBCODE_QW,
  input wire I_EMPHASIS,
  input wire I_MOTOR_LINE3,
  input wire I_MOTOR_LINE4,
  // pins and controls
  output reg O_OFFTRACK,
  output reg O_KILL,
  output reg O_PIN_THREE,
  output reg O_PIN_FOUR,
  output reg O_PIN_FIVE,
  output reg O_FOUR_LINE_MOTOR,
  output reg O_DEEMPH_BYPASS,
  output reg O_AUDIO_FEATURES_EN,
  output reg O_LOCK_TO_DISC,
  output reg O_BRAKE_SIX_PCT,
  output reg O_SUBCODE_EN,
  output reg O_SUBCODE_THREE_WIRE,
  output reg O_ALT_BANK_EN
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg [3:0] pins_a_reg;
  reg [3:0] pins_b_reg;
  reg [3:0] audio_reg;
  reg [3:0] subbank_reg;

  reg aw_got_reg;
  reg w_got_reg;
  reg [`DDPM_ADDR_W-1:0] awaddr_reg;
  reg [3:0] wdata_reg;
  reg wstrb0_reg;

  reg pin_one_meta_reg;
  reg pin_one_sync_reg;

  wire [5:0] w_idx;
  wire [5:0] r_idx;
  wire do_write;
  wire alt_bank;
  wire w_main;
  wire w_local;
  wire w_ok;
  wire four_line;
  wire [1:0] pin4_mode;
  wire [1:0] pin5_mode;
  wire offtrack_sel;

  // next pin levels
  reg offtrack_next;
  reg kill_next;
  reg pin_three_next;
  reg pin_four_next;
  reg pin_five_next;

  reg [31:0] rdata_next;
  reg rerr_next;

  ////////////////////////////////////////////////////////////////////////////
  // pin one synchroniser; the first stage feeds nothing else

  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      pin_one_meta_reg <= 1'b0;
      pin_one_sync_reg <= 1'b0;
    end else begin
      pin_one_meta_reg <= I_PIN_ONE;
      pin_one_sync_reg <= pin_one_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data accepted in either order

  assign O_AWREADY = !aw_got_reg && !O_BVALID;
  assign O_WREADY = !w_got_reg && !O_BVALID;
  assign do_write = aw_got_reg && w_got_reg;

  assign w_idx = awaddr_reg[`DDPM_IDX_MSB:`DDPM_IDX_LSB];
  assign alt_bank = subbank_reg[`DDPM_F_ALT_BANK];
  // once the shadow bank is on, the bank select itself is shadowed too,
  // so only reset returns to the main set
  assign w_main = !alt_bank && (w_idx <= `DDPM_IDX_LAST_MAIN);
  assign w_local = !alt_bank && (w_idx >= `DDPM_IDX_PINS_A) && (w_idx <= `DDPM_IDX_SUBBANK);
  // the shadow bank holds sixteen entries; higher indices are refused
  assign w_ok = alt_bank ? (w_idx <= `DDPM_IDX_SUBBANK) : (w_main || w_local);

  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= {`DDPM_ADDR_W{1'b0}};
      wdata_reg <= 4'h0;
      wstrb0_reg <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `DDPM_RESP_OKAY;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= I_AWADDR;
      end
      if (I_WVALID && O_WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= I_WDATA[3:0];
        wstrb0_reg <= I_WSTRB[0];
      end
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= w_ok ? `DDPM_RESP_OKAY : `DDPM_RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // local registers; only byte lane 0 carries the 4-bit fields

  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      pins_a_reg <= `DDPM_RST_PINS_A;
      pins_b_reg <= `DDPM_RST_PINS_B;
      audio_reg <= `DDPM_RST_AUDIO;
      subbank_reg <= `DDPM_RST_SUBBANK;
    end else if (do_write && w_local && wstrb0_reg) begin
      case (w_idx)
        `DDPM_IDX_PINS_A: pins_a_reg <= wdata_reg;
        `DDPM_IDX_PINS_B: pins_b_reg <= wdata_reg;
        `DDPM_IDX_AUDIO: audio_reg <= wdata_reg;
        `DDPM_IDX_SUBBANK: subbank_reg <= wdata_reg;
        default: pins_a_reg <= pins_a_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pass-through strobes toward the lower main registers and the shadow bank

  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_MAIN_WE <= 1'b0;
      O_MAIN_ADDR <= 4'h0;
      O_MAIN_DATA <= 4'h0;
      O_SHADOW_WE <= 1'b0;
      O_SHADOW_ADDR <= 4'h0;
      O_SHADOW_DATA <= 4'h0;
    end else begin
      O_MAIN_WE <= do_write && w_main && wstrb0_reg;
      O_SHADOW_WE <= do_write && alt_bank && w_ok && wstrb0_reg;
      if (do_write) begin
        O_MAIN_ADDR <= w_idx[3:0];
        O_MAIN_DATA <= wdata_reg;
        O_SHADOW_ADDR <= w_idx[3:0];
        O_SHADOW_DATA <= wdata_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel; of the write-only registers only the four local ones read back for debug

  assign O_ARREADY = !O_RVALID;
  assign r_idx = I_ARADDR[`DDPM_IDX_MSB:`DDPM_IDX_LSB];
  // pin one reads through the synchroniser, so a pulse under one cycle may be missed

  always @* begin
    rdata_next = 32'h00000000;
    rerr_next = 1'b0;
    case (r_idx)
      `DDPM_IDX_PINS_A: rdata_next[3:0] = pins_a_reg;
      `DDPM_IDX_PINS_B: rdata_next[3:0] = pins_b_reg;
      `DDPM_IDX_AUDIO: rdata_next[3:0] = audio_reg;
      `DDPM_IDX_SUBBANK: rdata_next[3:0] = subbank_reg;
      `DDPM_IDX_STATUS: begin
        rdata_next[`DDPM_S_PIN_ONE] = pin_one_sync_reg;
        rdata_next[`DDPM_S_OFFTRACK] = O_OFFTRACK;
        rdata_next[`DDPM_S_ALT_BANK] = alt_bank;
        rdata_next[`DDPM_S_FOUR_LINE] = four_line;
      end
      default: rerr_next = 1'b1;
    endcase
  end

  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `DDPM_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA <= rdata_next;
      O_RRESP <= rerr_next ? `DDPM_RESP_SLVERR : `DDPM_RESP_OKAY;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin and feature decode

  assign offtrack_sel = pins_a_reg[`DDPM_A_EXT_OFFTRACK];
  assign four_line = (pins_b_reg == `DDPM_B_FOUR_LINE);
  assign pin4_mode = pins_b_reg[`DDPM_B_PIN4_MSB:`DDPM_B_PIN4_LSB];
  assign pin5_mode = pins_b_reg[`DDPM_B_PIN5_MSB:`DDPM_B_PIN5_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // next pin levels; motor lines take both pins over in four-line mode

  always @* begin
    offtrack_next = I_OFFTRACK_INT;
    kill_next = I_KILL_L;
    pin_three_next = I_KILL_R;
    pin_four_next = 1'b0;
    pin_five_next = 1'b0;
    // off-track source
    if (offtrack_sel) begin
      offtrack_next = pin_one_sync_reg;
    end else begin
      offtrack_next = I_OFFTRACK_INT;
    end
    // kill routing; single output mutes only when both channels are silent
    if (!pins_a_reg[`DDPM_A_SINGLE_KILL]) begin
      kill_next = I_KILL_L;
      pin_three_next = I_KILL_R;
    end else begin
      kill_next = I_KILL_L && I_KILL_R;
      pin_three_next = pins_a_reg[`DDPM_A_PIN3_LEVEL];
    end
    if (four_line) begin
      pin_four_next = I_MOTOR_LINE3;
      pin_five_next = I_MOTOR_LINE4;
    end else begin
      case (pin4_mode)
        `DDPM_PIN_SIGNAL: pin_four_next = I_SUBCODE_QW;
        `DDPM_PIN_HIGH: pin_four_next = 1'b1;
        default: pin_four_next = 1'b0;
      endcase
      case (pin5_mode)
        `DDPM_PIN_SIGNAL: pin_five_next = I_EMPHASIS;
        `DDPM_PIN_HIGH: pin_five_next = 1'b1;
        default: pin_five_next = 1'b0;
      endcase
    end
  end

  // outputs registered so the pins never glitch while the mux settles
  always @(posedge I_CLK) begin
    if (!I_NRST) begin
      O_OFFTRACK <= 1'b0;
      O_KILL <= 1'b0;
      O_PIN_THREE <= 1'b0;
      O_PIN_FOUR <= 1'b1;
      O_PIN_FIVE <= 1'b1;
      O_FOUR_LINE_MOTOR <= 1'b0;
      O_DEEMPH_BYPASS <= 1'b0;
      O_AUDIO_FEATURES_EN <= 1'b1;
      O_LOCK_TO_DISC <= 1'b0;
      O_BRAKE_SIX_PCT <= 1'b0;
      O_SUBCODE_EN <= 1'b0;
      O_SUBCODE_THREE_WIRE <= 1'b0;
      O_ALT_BANK_EN <= 1'b0;
    end else begin
      // off-track and kill routing
      O_OFFTRACK <= offtrack_next;
      O_KILL <= kill_next;
      O_PIN_THREE <= pin_three_next;

      // pins four and five
      O_FOUR_LINE_MOTOR <= four_line;
      O_PIN_FOUR <= pin_four_next;
      O_PIN_FIVE <= pin_five_next;

      // bypass only while the emphasis flag is on the pin
      O_DEEMPH_BYPASS <= !four_line && (pin5_mode == `DDPM_PIN_SIGNAL);

      // audio, lock and brake
      O_AUDIO_FEATURES_EN <= (audio_reg[`DDPM_E_AUDIO_MSB:`DDPM_E_AUDIO_LSB] == `DDPM_E_AUDIO_ON);
      O_LOCK_TO_DISC <= audio_reg[`DDPM_E_LOCK_DISC];
      O_BRAKE_SIX_PCT <= audio_reg[`DDPM_E_BRAKE_SIX];

      // subcode interface and bank select
      O_SUBCODE_EN <= subbank_reg[`DDPM_F_SUB_ON];
      O_SUBCODE_THREE_WIRE <= subbank_reg[`DDPM_F_THREE_WIRE];
      O_ALT_BANK_EN <= alt_bank;
    end
  end

endmodule // ddpm_regs

`default_nettype wire

//--- testbench/ddpm_checker.sv
`default_nettype none
module ddpm_checker (
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic O_AWREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_MAIN_WE,
  input wire logic O_SHADOW_WE,
  input wire logic O_ALT_BANK_EN,
  input wire logic O_PIN_FOUR,
  input wire logic O_PIN_FIVE,
  input wire logic O_AUDIO_FEATURES_EN,
  input wire logic O_DEEMPH_BYPASS,
  input wire logic O_FOUR_LINE_MOTOR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  property p_rst;
    $rose(I_NRST) |-> O_PIN_FOUR && O_PIN_FIVE && O_AUDIO_FEATURES_EN && !O_ALT_BANK_EN;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_sticky;
    O_ALT_BANK_EN |=> O_ALT_BANK_EN;
  endproperty
  a_sticky: assert property (p_sticky) else $error("bank enable dropped");
  property p_nomain;
    O_ALT_BANK_EN |-> !O_MAIN_WE;
  endproperty
  a_nomain: assert property (p_nomain) else $error("main write in shadow mode");
  property p_shadow;
    O_SHADOW_WE |-> O_ALT_BANK_EN;
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow write without bank");
  property p_bypass;
    O_DEEMPH_BYPASS |-> !O_FOUR_LINE_MOTOR;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass in motor mode");
  property p_bhold;
    O_BVALID && !I_BREADY |=> O_BVALID && !O_AWREADY;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer lost");
  property p_rhold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer lost");
  property p_pulse;
    O_MAIN_WE |=> !O_MAIN_WE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("main strobe too long");
endmodule // ddpm_checker
bind ddpm_regs ddpm_checker chk (.*);
`default_nettype wire

//--- testbench/ddpm_host.sv
`default_nettype none
module ddpm_host (
  input wire logic i_clk,
  output logic [7:0] o_ad,
  output logic o_awv,
  input wire logic i_awr,
  output logic [31:0] o_wd,
  output logic o_wv,
  input wire logic i_wr,
  input wire logic [1:0] i_b,
  input wire logic i_bv,
  output logic o_br,
  output logic o_arv,
  input wire logic i_arr,
  input wire logic [31:0] i_rd,
  input wire logic [1:0] i_rr,
  input wire logic i_rv,
  output logic o_rr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tmo;
  // cycles the host waits before raising a ready
  int hold = 0;
  initial begin
    {o_ad, o_awv, o_wd, o_wv, o_br, o_arv, o_rr} = '0;
    tmo = 1'b0;
  end
  task automatic wr(input logic [5:0] ix, input logic [3:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    o_ad <= {ix, 2'h0};
    o_wd <= {28'h0, d};
    o_awv <= 1'b1;
    o_wv <= 1'b1;
    o_br <= (hold == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_awr) o_awv <= 1'b0;
      // released data shows the inverse, never the stale word
      if (i_wr) o_wd <= ~o_wd;
      if (i_wr) o_wv <= 1'b0;
      if (i_bv && o_br) break;
      if (n + 1 >= hold) o_br <= 1'b1;
    end
    r = i_b;
    o_br <= 1'b0;
    if (n == 40) tmo = 1'b1;
  endtask
  task automatic rd(input logic [5:0] ix, output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge i_clk);
    o_ad <= {ix, 2'h0};
    o_arv <= 1'b1;
    o_rr <= (hold == 0);
    for (n = 0; n < 40; n++) begin
      @(posedge i_clk);
      if (i_arr) o_arv <= 1'b0;
      if (i_rv && o_rr) break;
      if (n + 1 >= hold) o_rr <= 1'b1;
    end
    q = i_rd;
    r = i_rr;
    o_rr <= 1'b0;
    if (n == 40) tmo = 1'b1;
  endtask
endmodule // ddpm_host
`default_nettype wire

//--- testbench/ddpm_regs_tb.sv
`default_nettype none
`define CK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module ddpm_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [7:0] ad, src;
  logic [31:0] wd, rdat;
  logic [1:0] b, rrsp;
  logic [3:0] maddr, mdat, sadr, sdat;
  wire logic [12:0] ov;
  int mismatches = 0;
  int total_checks = 0;
  ddpm_host host (.i_clk(clk), .o_ad(ad), .o_awv(awv), .i_awr(awr), .o_wd(wd), .o_wv(wv), .i_wr(wr),
    .i_b(b), .i_bv(bv), .o_br(br), .o_arv(arv), .i_arr(arr), .i_rd(rdat), .i_rr(rrsp), .i_rv(rv), .o_rr(rr));
  ddpm_regs dut (.I_CLK(clk), .I_NRST(nrst), .I_AWADDR(ad), .I_AWPROT(3'h0), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(b),
    .O_BVALID(bv), .I_BREADY(br), .I_ARADDR(ad), .I_ARPROT(3'h0), .I_ARVALID(arv), .O_ARREADY(arr),
    .O_RDATA(rdat), .O_RRESP(rrsp), .O_RVALID(rv), .I_RREADY(rr), .O_MAIN_WE(), .O_MAIN_ADDR(maddr),
    .O_MAIN_DATA(mdat), .O_SHADOW_WE(), .O_SHADOW_ADDR(sadr), .O_SHADOW_DATA(sdat),
    .I_PIN_ONE(src[7]), .I_OFFTRACK_INT(src[6]), .I_KILL_L(src[5]), .I_KILL_R(src[4]),
    .I_SUBCODE_QW(src[3]), .I_EMPHASIS(src[2]), .I_MOTOR_LINE3(src[1]), .I_MOTOR_LINE4(src[0]),
    .O_OFFTRACK(ov[12]), .O_KILL(ov[11]), .O_PIN_THREE(ov[10]), .O_PIN_FOUR(ov[9]), .O_PIN_FIVE(ov[8]),
    .O_FOUR_LINE_MOTOR(ov[7]), .O_DEEMPH_BYPASS(ov[6]), .O_AUDIO_FEATURES_EN(ov[5]),
    .O_LOCK_TO_DISC(ov[4]), .O_BRAKE_SIX_PCT(ov[3]), .O_SUBCODE_EN(ov[2]),
    .O_SUBCODE_THREE_WIRE(ov[1]), .O_ALT_BANK_EN(ov[0]));
  ////////////////////////////////////////////////////////////
  function automatic logic pv(input logic [1:0] c, input logic s);
    pv = (c == 2'h1) ? s : (c == 2'h3);
  endfunction
  function automatic logic [12:0] expv(input logic [3:0] a, bb, e, f, input logic [7:0] s);
    logic fl;
    fl = (bb == 4'h0);
    expv = {a[0] ? s[7] : s[6], a[1] ? (s[5] & s[4]) : s[5], a[1] ? a[2] : s[4],
      fl ? s[1] : pv(bb[1:0], s[3]), fl ? s[0] : pv(bb[3:2], s[2]), fl, !fl && bb[3:2] == 2'h1,
      e[3:2] == 2'h1, e[1], e[0], f[2], f[3], f[0]};
  endfunction
  task automatic reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic close_out();
    if (host.tmo) mismatches++;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (host.tmo) close_out();
  initial begin
    logic [3:0] rg [4];
    logic [1:0] r;
    logic [31:0] q;
    int k, x, v;
    src = 8'h00;
    nrst = 1'b0;
    rg = '{4'h2, 4'hF, 4'h4, 4'h0};
    x = $urandom(32'h492CDB0F);
    reset();
    `CK(ov, expv(rg[0], rg[1], rg[2], rg[3], src))
    // full code sweep first, then random writes; bank bit kept off here
    for (k = 0; k < 100; k++) begin
      x = (k < 64) ? k / 16 : $urandom % 4;
      v = (k < 64) ? k % 16 : $urandom % 16;
      if (x == 3) v = v & 14;
      src <= 8'($urandom);
      host.hold = $urandom % 4;
      host.wr(6'(12 + x), 4'(v), r);
      `CK(r, 2'h0)
      rg[x] = 4'(v);
      host.rd(6'(12 + x), q, r);
      `CK(q, {28'h0, rg[x]})
      `CK(r, 2'h0)
      `CK(ov, expv(rg[0], rg[1], rg[2], rg[3], src))
      host.rd(6'h10, q, r);
      `CK({r, q}, {30'h0, rg[1] == 4'h0, 1'b0, rg[0][0] ? src[7] : src[6], src[7]})
    end
    $display("sweep done");
    host.wr(6'h05, 4'h9, r);
    `CK({maddr, mdat}, 8'h59)
    host.wr(6'h11, 4'h1, r);
    `CK(r, 2'h2)
    host.rd(6'h05, q, r);
    `CK({r, q}, {2'h2, 32'h0})
    host.wr(6'h0F, 4'h1, r);
    host.wr(6'h0C, 4'h1, r);
    `CK({sadr, sdat}, 8'hC1)
    rg[3] = 4'h1;
    `CK(ov, expv(rg[0], rg[1], rg[2], rg[3], src))
    host.rd(6'h10, q, r);
    `CK(q[2], 1'b1)
    $display("bank done");
    reset();
    rg = '{4'h2, 4'hF, 4'h4, 4'h0};
    `CK(ov, expv(rg[0], rg[1], rg[2], rg[3], src))
    $display("reset done");
    close_out();
  end
endmodule // ddpm_regs_tb
`default_nettype wire
